//--- core/tmra_consts.svh
// register offsets, field positions, encodings and reset values of the timer
`ifndef TMRA_CONSTS_SVH
`define TMRA_CONSTS_SVH

`define TMRA_ADDR_CONTROL    8'hE2
`define TMRA_ADDR_PRESCALE   8'hE3
`define TMRA_ADDR_COUNT      8'hE4
`define TMRA_ADDR_REFERENCE  8'hE5

`define TMRA_CONTROL_RESET   8'h00
`define TMRA_PRESCALE_RESET  3'h0
`define TMRA_COUNT_RESET     8'h00
`define TMRA_REFERENCE_RESET 8'h00
`define TMRA_RDATA_UNMAPPED  8'h00

`define TMRA_BIT_OVF_PEND    0
`define TMRA_BIT_MATCH_PEND  1
`define TMRA_BIT_OVF_IE      2
`define TMRA_BIT_MATCH_IE    3
`define TMRA_BIT_CLEAR       5
`define TMRA_MODE_LO         6
`define TMRA_MODE_HI         7

`define TMRA_MODE_INTERVAL   2'h0
`define TMRA_MODE_CAP_FALL   2'h1
`define TMRA_MODE_CAP_RISE   2'h2
`define TMRA_MODE_PWM        2'h3

`define TMRA_SEL_LO          0
`define TMRA_SEL_HI          2
`define TMRA_SEL_DIV1        3'h0
`define TMRA_SEL_DIV8        3'h1
`define TMRA_SEL_DIV64       3'h2
`define TMRA_SEL_DIV256      3'h3
`define TMRA_SEL_DIV1024     3'h4
`define TMRA_SEL_EXT_RISE    3'h5
`define TMRA_SEL_EXT_FALL    3'h6
`define TMRA_SEL_STOP        3'h7

`define TMRA_DIV_W           10
`define TMRA_DIV8_MASK       10'h007
`define TMRA_DIV64_MASK      10'h03F
`define TMRA_DIV256_MASK     10'h0FF
`define TMRA_DIV1024_MASK    10'h3FF
`define TMRA_DIV_RESET       10'h000

`define TMRA_CAP_ROUTE_LO    6
`define TMRA_CAP_ROUTE_HI    7
`define TMRA_CAP_ROUTE_TIMER 2'h0

`define TMRA_COUNT_ZERO      8'h00
`define TMRA_COUNT_MAX       8'hFF
`define TMRA_COUNT_ONE       8'h01

`endif

//--- core/tmra_pkg.sv
// types shared by the timer files
`include "tmra_consts.svh"

package tmra_pkg;

  typedef enum logic [1:0] {
    TMRA_INTERVAL = `TMRA_MODE_INTERVAL,
    TMRA_CAP_FALL = `TMRA_MODE_CAP_FALL,
    TMRA_CAP_RISE = `TMRA_MODE_CAP_RISE,
    TMRA_PWM      = `TMRA_MODE_PWM
  } tmra_mode_t;

endpackage : tmra_pkg

//--- core/tmra_prescaler.sv
// clock divider and external count clock selection, one tick per count
`include "tmra_consts.svh"

module tmra_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] clk_sel,
  input  wire logic       ext_clk_pin,
  output logic            tick
);

  logic [`TMRA_DIV_W-1:0] div;
  logic                   ext_meta;
  logic                   ext_sync;
  logic                   ext_prev;
  logic                   next_tick;

  // free-running divider; timer_prescale_select share it so a ratio change needs no restart
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div <= `TMRA_DIV_RESET;
    end else begin
      div <= div + 1'b1;
    end
  end

  // the pin is asynchronous, so two flops before the edge detector
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_clk_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  always_comb begin
    next_tick = 1'b0;
    unique case (clk_sel)
      `TMRA_SEL_DIV1:     next_tick = 1'b1;
      `TMRA_SEL_DIV8:     next_tick = (div & `TMRA_DIV8_MASK) == `TMRA_DIV8_MASK;
      `TMRA_SEL_DIV64:    next_tick = (div & `TMRA_DIV64_MASK) == `TMRA_DIV64_MASK;
      `TMRA_SEL_DIV256:   next_tick = (div & `TMRA_DIV256_MASK) == `TMRA_DIV256_MASK;
      `TMRA_SEL_DIV1024:  next_tick = div == `TMRA_DIV1024_MASK;
      `TMRA_SEL_EXT_RISE: next_tick = ext_sync & ~ext_prev;
      `TMRA_SEL_EXT_FALL: next_tick = ~ext_sync & ext_prev;
      `TMRA_SEL_STOP:     next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick <= 1'b0;
    end else begin
      tick <= next_tick;
    end
  end

endmodule : tmra_prescaler

//--- core/tmra_timer.sv
// eight-bit timer with interval, capture and pwm modes and its registers
`include "tmra_consts.svh"

// Functional notes
// - one of interval, capture or pwm mode
// - count clock: divided system clock or pin
// - reset clears control: interval, undivided, irqs off
// - writing one to control bit 5 clears counter
// - overflow pending cleared by service or software
// - match irq requested only while bit 3 set
// - bit 1 pending sticks; software writes zero
// - interval match toggles pin, requests, clears counter
// - pwm match keeps counting, wraps FF to 00
// - pwm pin low when reference <= counter
// - pwm period is 256 timer clocks
// - capture edge copies counter into reference register
// - software picks rising or falling capture edge
// - capture pin routed when port bits 7:6 are 00
// - capture mode raises overflow and capture irqs
module tmra_timer (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       ovf_irq_ack,
  input  wire logic [7:0] port_four_low_config,
  input  wire logic       external_count_clock_pin,
  input  wire logic       capture_input_pin,
  output logic            toggle_pwm_output_pin,
  output logic            overflow_irq,
  output logic            match_capture_irq
);

  // control register fields
  tmra_pkg::tmra_mode_t   mode;
  logic                   ovf_ie;
  logic                   match_ie;
  logic                   ovf_pend;
  logic                   match_pend;

  // prescale select and data path
  logic [2:0]             clk_sel;
  logic [7:0]             count_value;
  logic [7:0]             reference_capture_value;
  logic [7:0]             next_count;
  logic [7:0]             control_rd;
  logic [7:0]             next_rdata;

  // decode and events
  logic                   wr_control;
  logic                   wr_prescale;
  logic                   wr_reference;
  logic                   clear_req;
  logic                   tick;
  logic                   clk_running;
  logic                   is_interval;
  logic                   is_pwm;
  logic                   is_capture;
  logic                   at_reference;
  logic                   at_max;
  logic                   match_hit;
  logic                   wrap_hit;
  logic                   capture_hit;
  logic                   cap_routed;
  logic                   cap_meta;
  logic                   cap_sync;
  logic                   cap_prev;
  logic                   cap_rise;
  logic                   cap_fall;
  logic                   cap_edge;

  // register decode
  assign wr_control   = reg_write && (reg_addr == `TMRA_ADDR_CONTROL);
  assign wr_prescale  = reg_write && (reg_addr == `TMRA_ADDR_PRESCALE);
  assign wr_reference = reg_write && (reg_addr == `TMRA_ADDR_REFERENCE);
  assign clear_req    = wr_control && reg_wdata[`TMRA_BIT_CLEAR];

  // mode decode
  assign is_interval = (mode == tmra_pkg::TMRA_INTERVAL);
  assign is_pwm      = (mode == tmra_pkg::TMRA_PWM);
  assign is_capture  = (mode == tmra_pkg::TMRA_CAP_RISE) ||
                       (mode == tmra_pkg::TMRA_CAP_FALL);

  assign clk_running  = (clk_sel != `TMRA_SEL_STOP);
  assign at_reference = (count_value == reference_capture_value);
  assign at_max       = (count_value == `TMRA_COUNT_MAX);

  tmra_prescaler u_prescaler (
    .clk         (clk),
    .rst_b       (rst_b),
    .clk_sel     (clk_sel),
    .ext_clk_pin (external_count_clock_pin),
    .tick        (tick)
  );

  // control register: mode and enables, reset to interval and irqs off
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode     <= tmra_pkg::TMRA_INTERVAL;
      ovf_ie   <= 1'b0;
      match_ie <= 1'b0;
    end else if (wr_control) begin
      mode     <= tmra_pkg::tmra_mode_t'(reg_wdata[`TMRA_MODE_HI:`TMRA_MODE_LO]);
      ovf_ie   <= reg_wdata[`TMRA_BIT_OVF_IE];
      match_ie <= reg_wdata[`TMRA_BIT_MATCH_IE];
    end
  end

  // prescale select; reset picks the undivided system clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clk_sel <= `TMRA_PRESCALE_RESET;
    end else if (wr_prescale) begin
      clk_sel <= reg_wdata[`TMRA_SEL_HI:`TMRA_SEL_LO];
    end
  end

  // capture pin: two flops, then an edge detector on the settled copy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
      cap_prev <= 1'b0;
    end else begin
      cap_meta <= capture_input_pin;
      cap_sync <= cap_meta;
      cap_prev <= cap_sync;
    end
  end

  assign cap_rise = cap_sync & ~cap_prev;
  assign cap_fall = ~cap_sync & cap_prev;
  assign cap_edge = (mode == tmra_pkg::TMRA_CAP_RISE) ? cap_rise : cap_fall;

  // the pin only reaches the timer while the port routes it here
  assign cap_routed = (port_four_low_config[`TMRA_CAP_ROUTE_HI:`TMRA_CAP_ROUTE_LO]
                       == `TMRA_CAP_ROUTE_TIMER);

  // a stopped clock also blocks captures so no new irq appears
  assign capture_hit = is_capture && cap_routed && cap_edge &&
                       clk_running && !clear_req;

  // counter step, match and wrap, evaluated only on a tick
  always_comb begin
    next_count = count_value;
    match_hit  = 1'b0;
    wrap_hit   = 1'b0;
    if (clear_req) begin
      next_count = `TMRA_COUNT_ZERO;
    end else if (tick) begin
      if (is_interval && at_reference) begin
        next_count = `TMRA_COUNT_ZERO;
        match_hit  = 1'b1;
      end else begin
        // plain wrap from FF to 00 gives the 256 tick pwm period
        next_count = count_value + `TMRA_COUNT_ONE;
        wrap_hit   = at_max;
        match_hit  = is_pwm && at_reference;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_value <= `TMRA_COUNT_RESET;
    end else begin
      count_value <= next_count;
    end
  end

  // reference register: a capture beats a software write in the same cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reference_capture_value <= `TMRA_REFERENCE_RESET;
    end else if (capture_hit) begin
      reference_capture_value <= count_value;
    end else if (wr_reference) begin
      reference_capture_value <= reg_wdata;
    end
  end

  // overflow pending: set wins over the service ack and the software clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_pend <= 1'b0;
    end else if (wrap_hit) begin
      ovf_pend <= 1'b1;
    end else if (ovf_irq_ack) begin
      ovf_pend <= 1'b0;
    end else if (wr_control && !reg_wdata[`TMRA_BIT_OVF_PEND]) begin
      ovf_pend <= 1'b0;
    end
  end

  // match/capture pending: sticky until software writes zero to it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      match_pend <= 1'b0;
    end else if (match_hit || capture_hit) begin
      match_pend <= 1'b1;
    end else if (wr_control && !reg_wdata[`TMRA_BIT_MATCH_PEND]) begin
      match_pend <= 1'b0;
    end
  end

  // interrupt requests follow the pending bits gated by their enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= ovf_pend && ovf_ie;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      match_capture_irq <= 1'b0;
    end else begin
      match_capture_irq <= match_pend && match_ie;
    end
  end

  // output pin: toggles on interval match, compare level in pwm,
  // and holds its level in capture mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      toggle_pwm_output_pin <= 1'b0;
    end else if (is_pwm) begin
      toggle_pwm_output_pin <= (reference_capture_value > count_value);
    end else if (is_interval && match_hit) begin
      toggle_pwm_output_pin <= ~toggle_pwm_output_pin;
    end
  end

  // control readback; the clear bit and bit 4 always read zero
  always_comb begin
    control_rd = `TMRA_CONTROL_RESET;
    control_rd[`TMRA_MODE_HI:`TMRA_MODE_LO] = mode;
    control_rd[`TMRA_BIT_MATCH_IE]   = match_ie;
    control_rd[`TMRA_BIT_OVF_IE]     = ovf_ie;
    control_rd[`TMRA_BIT_MATCH_PEND] = match_pend;
    control_rd[`TMRA_BIT_OVF_PEND]   = ovf_pend;
  end

  // read mux, registered so read data lags the address by one clock
  always_comb begin
    next_rdata = `TMRA_RDATA_UNMAPPED;
    unique case (reg_addr)
      `TMRA_ADDR_CONTROL:   next_rdata = control_rd;
      `TMRA_ADDR_PRESCALE:  next_rdata = {5'h00, clk_sel};
      `TMRA_ADDR_COUNT:     next_rdata = count_value;
      `TMRA_ADDR_REFERENCE: next_rdata = reference_capture_value;
      default:              next_rdata = `TMRA_RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `TMRA_RDATA_UNMAPPED;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : tmra_timer

//--- verif/eight_bit_timer_capture_pwm_tb.sv
// self-checking bench for the eight-bit timer
module eight_bit_timer_capture_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       rst_b;
  logic [7:0] reg_addr;
  logic       reg_write;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       ovf_irq_ack;
  logic [7:0] port_four_low_config;
  logic       ext_pin;
  logic       cap_pin;
  logic       out_pin;
  logic       ovf_irq;
  logic       mc_irq;
  logic [7:0] rd_val;
  int         miscompares;
  int         n_checks;
  int         n;
  int         divs [5] = '{1, 8, 64, 256, 1024};

  tmra_timer uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ovf_irq_ack(ovf_irq_ack), .port_four_low_config(port_four_low_config),
    .external_count_clock_pin(ext_pin), .capture_input_pin(cap_pin), .toggle_pwm_output_pin(out_pin),
    .overflow_irq(ovf_irq), .match_capture_irq(mc_irq));
  tmra_pin_partner u_pins (.clk(clk), .cap_pin(cap_pin), .ext_pin(ext_pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // strobe stays up across back-to-back writes; reads and idles drop it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    reg_write = 1'b0;
    reg_addr = a;
    @(negedge clk);
    rd_val = reg_rdata;
  endtask : rd
  task automatic idle(input int c);
    reg_write = 1'b0;
    repeat (c) @(negedge clk);
  endtask : idle
  task automatic gap(output int g);
    logic v;
    reg_write = 1'b0;
    v = out_pin;
    for (g = 0; g < 600 && out_pin === v; g++) @(negedge clk);
  endtask : gap
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // tests need about 6600 cycles; allow nearly four times that
  initial begin
    #100000;
    miscompares++;
    close_out();
  end

  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    ovf_irq_ack = 1'b0;
    port_four_low_config = 8'h00;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    rd(8'hE2); check("control", rd_val, 8'h00);
    rd(8'hE5); check("reference", rd_val, 8'h00);
    rd(8'hE6); check("unmapped", rd_val, 8'h00);
    wr(8'hE3, 8'h07);
    wr(8'hE2, 8'h20);
    rd(8'hE4); check("count cleared", rd_val, 8'h00);
    idle(10);
    rd(8'hE4); check("count stopped", rd_val, 8'h00);
    rd(8'hE2); check("no pending stopped", rd_val, 8'h00);
    $display("reset and clear done");
    wr(8'hE5, 8'h05);
    wr(8'hE2, 8'h28);
    wr(8'hE3, 8'h00);
    gap(n);
    gap(n);
    check("toggle period", 8'(n), 8'h06);
    wr(8'hE3, 8'h07);
    rd(8'hE2); check("match pending", rd_val, 8'h0A);
    check("match irq", 8'(mc_irq), 8'h01);
    wr(8'hE2, 8'h02);
    idle(3); check("irq masked", 8'(mc_irq), 8'h00);
    wr(8'hE2, 8'h0A);
    idle(3); check("irq unmasked", 8'(mc_irq), 8'h01);
    wr(8'hE2, 8'h08);
    idle(3); check("irq cleared", 8'(mc_irq), 8'h00);
    $display("interval done");
    // five divided timer_prescale_select, then the pin on either edge
    for (int k = 0; k < 7; k++) begin
      wr(8'hE2, 8'hE0);
      wr(8'hE3, 8'(k));
      idle(k < 5 ? divs[k] * 4 : 1);
      if (k >= 5) u_pins.ext_pulses(5);
      if (k >= 5) idle(8);
      wr(8'hE3, 8'h07);
      rd(8'hE4);
      check("ticks", 8'(k < 5 ? (rd_val >= 3 && rd_val <= 6) : rd_val == 5), 8'h01);
    end
    $display("clock select done");
    wr(8'hE5, 8'h40);
    wr(8'hE2, 8'hE4);
    wr(8'hE3, 8'h00);
    idle(4);
    n = 0;
    repeat (512) begin
      @(negedge clk);
      n += int'(out_pin === 1'b1);
    end
    check("pwm high time", 8'(n / 2), 8'h40);
    check("overflow irq", 8'(ovf_irq), 8'h01);
    wr(8'hE3, 8'h07);
    idle(8);
    // software clear of the overflow pending bit, match pending kept
    wr(8'hE2, 8'hC6);
    idle(2); check("sw clear drops irq", 8'(ovf_irq), 8'h00);
    // one more wrap so the service ack has something to clear
    wr(8'hE3, 8'h00);
    idle(260);
    wr(8'hE3, 8'h07);
    idle(8); check("overflow again", 8'(ovf_irq), 8'h01);
    ovf_irq_ack = 1'b1;
    @(negedge clk);
    ovf_irq_ack = 1'b0;
    idle(2); check("ack drops irq", 8'(ovf_irq), 8'h00);
    rd(8'hE2); check("after ack", rd_val, 8'hC6);
    $display("pwm done");
    wr(8'hE2, 8'hA8);
    wr(8'hE3, 8'h05);
    idle(1);
    u_pins.ext_pulses(3);
    port_four_low_config = 8'h40;
    u_pins.cap_set(1'b1);
    idle(8); check("unrouted capture 40", 8'(mc_irq), 8'h00);
    port_four_low_config = 8'h80;
    u_pins.cap_set(1'b0);
    u_pins.cap_set(1'b1);
    idle(8); check("unrouted capture 80", 8'(mc_irq), 8'h00);
    // only bits 7:6 route the pin; the low bits must not matter
    port_four_low_config = 8'h3F;
    u_pins.cap_set(1'b0);
    u_pins.cap_set(1'b1);
    idle(8); check("capture irq", 8'(mc_irq), 8'h01);
    rd(8'hE5); check("captured rise", rd_val, 8'h03);
    wr(8'hE2, 8'h68);
    idle(1);
    u_pins.ext_pulses(2);
    u_pins.cap_set(1'b0);
    idle(8);
    rd(8'hE5); check("captured fall", rd_val, 8'h02);
    wr(8'hE2, 8'h48);
    idle(1);
    u_pins.cap_set(1'b1);
    idle(8); check("rise ignored", 8'(mc_irq), 8'h00);
    $display("capture done");
    // reset again with registers written, then check control and prescale came back cleared
    rst_b = 1'b0;
    idle(2);
    rst_b = 1'b1;
    rd(8'hE2); check("control after reset", rd_val, 8'h00);
    rd(8'hE3); check("prescale after reset", rd_val, 8'h00);
    $display("second reset done");
    close_out();
  end
endmodule : eight_bit_timer_capture_pwm_tb

//--- verif/tmra_pin_partner.sv
// pin-side source driving the capture input and the external count clock
module tmra_pin_partner (
  input  wire logic clk,
  output logic      cap_pin,
  output logic      ext_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cap_pin = 1'b0;
    ext_pin = 1'b0;
  end
  // slow levels so the two-flop synchronisers never miss one
  task automatic cap_set(input logic lvl);
    repeat (8) @(negedge clk);
    cap_pin = lvl;
  endtask : cap_set
  task automatic ext_pulses(input int n);
    repeat (n) begin
      repeat (4) @(negedge clk);
      ext_pin = 1'b1;
      repeat (4) @(negedge clk);
      ext_pin = 1'b0;
    end
  endtask : ext_pulses
endmodule : tmra_pin_partner

//--- verif/tmra_timer_asserts.sv
// port checker for the timer, bound into its top module
module tmra_timer_asserts (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_write,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       ovf_irq_ack,
  input wire logic       toggle_pwm_output_pin,
  input wire logic       overflow_irq,
  input wire logic       match_capture_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       ctl_wr;
  logic [1:0] ie_q;
  logic [2:0] sel_q;
  assign ctl_wr = reg_write && reg_addr == 8'hE2;
  // shadows of what software last wrote, so no body signal is needed
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      ie_q <= 2'h0;
    else if (ctl_wr)
      ie_q <= reg_wdata[3:2];
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b)
      sel_q <= 3'h0;
    else if (reg_write && reg_addr == 8'hE3)
      sel_q <= reg_wdata[2:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property ($rose(rst_b) |-> !overflow_irq && !match_capture_irq)
    else $error("irq high right after reset");
  a_clear_reads_zero: assert property ($past(reg_addr) == 8'hE2 |-> reg_rdata[5:4] == 2'h0)
    else $error("control bits 5:4 read nonzero");
  a_clear_zeroes_count: assert property (ctl_wr && reg_wdata[5] ##1 reg_addr == 8'hE4 |=> reg_rdata <= 8'h01)
    else $error("count not cleared");
  a_stop_freezes_pin: assert property ((sel_q == 3'h7 && !reg_write) [*6] |-> $stable(toggle_pwm_output_pin))
    else $error("output pin moved with clock stopped");
  a_ovf_needs_enable: assert property (!ie_q[0] [*2] |-> !overflow_irq)
    else $error("overflow irq while disabled");
  a_match_needs_enable: assert property (!ie_q[1] [*2] |-> !match_capture_irq)
    else $error("match irq while disabled");
  a_ack_clears_ovf: assert property ((sel_q == 3'h7 && !reg_write) [*6] ##0 ovf_irq_ack |-> ##2 !overflow_irq)
    else $error("overflow irq survived ack");
  a_match_irq_holds: assert property (!ctl_wr ##1 match_capture_irq && !ctl_wr |=> match_capture_irq)
    else $error("match irq dropped without software clear");
endmodule : tmra_timer_asserts

bind tmra_timer tmra_timer_asserts u_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ovf_irq_ack(ovf_irq_ack),
  .toggle_pwm_output_pin(toggle_pwm_output_pin), .overflow_irq(overflow_irq), .match_capture_irq(match_capture_irq));
